// ### rtl/tm2_timer.sv
// Contract
// [R1] capture mode: trigger pin falling edge copies counter into reload/capture pair
// [R2] source select 0: count system clock, divided by one or twelve
// [R3] source select 1: each count pin falling edge increments the counter; in baud mode the code counts every second edge
// [R4] capture/reload modes: rollover from all ones sets overflow flag, requests interrupt
// [R5] capture mode needs capture select and run set, both baud bits clear
// [R6] capture only with external enable; otherwise trigger edges are ignored
// [R7] reload mode: overflow loads counter from reload pair, counting continues
// [R8] reload mode needs capture select clear and run set; run starts counting
// [R9] reload mode with external enable: trigger falling edge also reloads counter
// [R10] either baud bit selects baud mode, which reloads regardless of capture select
// [R11] baud mode: overflow reloads, no flag, pulses shift clock of chosen direction
// [R12] the UART divides the overflow pulse rate by sixteen
// [R13] baud mode with internal source counts system clock divided by two only
// [R14] external source baud rate is pin rate over 32 times reload distance
// [R15] baud mode with external enable: trigger falling edge sets external flag
// [R16] software uses this clock only while the UART runs variable-rate modes
// [R17] divide select 0 counts clock over twelve; 1 counts every clock
// [R18] both flags stay set until software writes zero; set beats clear
`timescale 1ns/10ps
`default_nettype none
`include "tm2_params.svh"

module tm2_timer (
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       arst_n_in,
  // special-function register port
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       sfr_wr_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic      [7:0] sfr_rdata_out,
  // clock control
  input  wire logic       clock_divide_select_in,
  // pins
  input  wire logic       ext_count_pin_in,
  input  wire logic       ext_trigger_pin_in,
  // events
  output logic            timer_irq_req_out,
  output logic            rx_shift_tick_out,
  output logic            tx_shift_tick_out
);

  tm2_tick_if ticks ();

  tm2_tick_gen u_tick_gen (
    .mclk_in            (mclk_in),
    .arst_n_in          (arst_n_in),
    .ext_count_pin_in   (ext_count_pin_in),
    .ext_trigger_pin_in (ext_trigger_pin_in),
    .ticks              (ticks.gen)
  );

  logic [7:0]        ctrl;
  logic [15:0]       count;
  logic [15:0]       reload;
  logic [7:0]        next_ctrl;
  logic [15:0]       next_count;
  logic [15:0]       next_reload;
  logic [7:0]        next_rdata;
  logic              next_irq;
  logic              next_rx_tick;
  logic              next_tx_tick;
  tm2_pkg::tm2_mode_t mode;
  // decode results shared by the next-value processes
  logic              inc_en;
  logic              ovf;
  logic              trig;
  // pin edge halving for baud mode
  logic              ext_half;
  logic              next_ext_half;

  // every control bit must sit inside the byte-wide register
  if (`TM2_BIT_OVF >= $bits(ctrl) || `TM2_BIT_CAP_RL < 0) begin : g_bad_bits
    $error("tm2_timer: control bit positions out of range");
  end

  always_comb begin
    // mode decode
    if (!ctrl[`TM2_BIT_RUN]) begin
      mode = tm2_pkg::TM2_OFF;
    end else if (ctrl[`TM2_BIT_RX_BAUD] | ctrl[`TM2_BIT_TX_BAUD]) begin
      mode = tm2_pkg::TM2_BAUD; // see [R10]
    end else if (ctrl[`TM2_BIT_CAP_RL]) begin
      mode = tm2_pkg::TM2_CAPTURE; // see [R5]
    end else begin
      mode = tm2_pkg::TM2_RELOAD; // see [R8]
    end

    // count enable
    if (mode == tm2_pkg::TM2_OFF) begin
      inc_en = 1'b0;
    end else if (ctrl[`TM2_BIT_SRC] && mode == tm2_pkg::TM2_BAUD) begin
      // pin timebase is halved in baud mode, as the internal one is
      inc_en = ticks.fall_count & ext_half; // see [R14]
    end else if (ctrl[`TM2_BIT_SRC]) begin
      inc_en = ticks.fall_count; // see [R3]
    end else if (mode == tm2_pkg::TM2_BAUD) begin
      inc_en = ticks.tick_baud; // see [R13]
    end else begin
      inc_en = clock_divide_select_in ? 1'b1 : ticks.tick_slow; // see [R2] [R17]
    end

    ovf  = inc_en && (count == `TM2_WORD_ALL_ONES);
    trig = ctrl[`TM2_BIT_EXT_EN] & ticks.fall_trig; // see [R6]
  end

  // next values of the software-visible timer state
  always_comb begin
    next_ctrl     = ctrl;
    next_count    = inc_en ? count + `TM2_WORD_ONE : count;
    next_reload   = reload;
    next_ext_half = 1'b0;
    // pin edge divider only runs in baud mode with the pin source
    if (mode == tm2_pkg::TM2_BAUD && ctrl[`TM2_BIT_SRC]) begin
      next_ext_half = ext_half ^ ticks.fall_count; // see [R14]
    end

    // software writes first, hardware events override
    if (sfr_wr_in) begin
      unique case (sfr_addr_in)
        `TM2_ADDR_CTRL:      next_ctrl = sfr_wdata_in;
        `TM2_ADDR_RELOAD_LO: next_reload[7:0] = sfr_wdata_in;
        `TM2_ADDR_RELOAD_HI: next_reload[15:8] = sfr_wdata_in;
        `TM2_ADDR_COUNT_LO:  next_count[7:0] = sfr_wdata_in;
        `TM2_ADDR_COUNT_HI:  next_count[15:8] = sfr_wdata_in;
        default:             next_ctrl = ctrl;
      endcase
    end

    unique case (mode)
      tm2_pkg::TM2_OFF: begin
        next_ctrl = next_ctrl;
      end
      tm2_pkg::TM2_CAPTURE: begin
        if (ovf) begin
          next_ctrl[`TM2_BIT_OVF] = 1'b1; // see [R4] [R18]
        end
        if (trig) begin
          next_reload = count; // see [R1]
          next_ctrl[`TM2_BIT_EXTF] = 1'b1; // see [R18]
        end
      end
      tm2_pkg::TM2_RELOAD: begin
        if (ovf) begin
          next_ctrl[`TM2_BIT_OVF] = 1'b1; // see [R4] [R18]
        end
        if (ovf || trig) begin
          next_count = reload; // see [R7] [R9]
        end
        if (trig) begin
          next_ctrl[`TM2_BIT_EXTF] = 1'b1; // see [R18]
        end
      end
      tm2_pkg::TM2_BAUD: begin
        if (ovf) begin
          next_count = reload; // see [R11]
        end
        if (trig) begin
          next_ctrl[`TM2_BIT_EXTF] = 1'b1; // see [R15] [R18]
        end
      end
    endcase
  end

  // next values of the registered outputs
  always_comb begin
    next_irq = next_ctrl[`TM2_BIT_OVF] | next_ctrl[`TM2_BIT_EXTF]; // see [R4] [R15]
    // overflow pulses reach the shift clock only for the chosen direction
    next_rx_tick = 1'b0;
    next_tx_tick = 1'b0;
    if (mode == tm2_pkg::TM2_BAUD && ovf) begin
      next_rx_tick = ctrl[`TM2_BIT_RX_BAUD]; // see [R11]
      next_tx_tick = ctrl[`TM2_BIT_TX_BAUD]; // see [R11]
    end

    unique case (sfr_addr_in)
      `TM2_ADDR_CTRL:      next_rdata = next_ctrl;
      `TM2_ADDR_RELOAD_LO: next_rdata = next_reload[7:0];
      `TM2_ADDR_RELOAD_HI: next_rdata = next_reload[15:8];
      `TM2_ADDR_COUNT_LO:  next_rdata = next_count[7:0];
      `TM2_ADDR_COUNT_HI:  next_rdata = next_count[15:8];
      default:             next_rdata = `TM2_BYTE_ZERO;
    endcase
  end

  // timer state
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl     <= `TM2_CTRL_RESET;
      count    <= `TM2_WORD_RESET;
      reload   <= `TM2_WORD_RESET;
      ext_half <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      count    <= next_count;
      reload   <= next_reload;
      ext_half <= next_ext_half;
    end
  end

  // outputs straight from flip-flops
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sfr_rdata_out     <= `TM2_BYTE_ZERO;
      timer_irq_req_out <= 1'b0;
      rx_shift_tick_out <= 1'b0;
      tx_shift_tick_out <= 1'b0;
    end else begin
      sfr_rdata_out     <= next_rdata;
      timer_irq_req_out <= next_irq;
      rx_shift_tick_out <= next_rx_tick;
      tx_shift_tick_out <= next_tx_tick;
    end
  end

endmodule

`default_nettype wire

// ### common/tm2_params.svh
`ifndef TM2_PARAMS_SVH
`define TM2_PARAMS_SVH

// register addresses on the special-function register port
`define TM2_ADDR_CTRL      8'hC8
`define TM2_ADDR_RELOAD_LO 8'hC9
`define TM2_ADDR_RELOAD_HI 8'hCA
`define TM2_ADDR_COUNT_LO  8'hCB
`define TM2_ADDR_COUNT_HI  8'hCC

// control register bit positions
`define TM2_BIT_OVF        7
`define TM2_BIT_EXTF       6
`define TM2_BIT_RX_BAUD    5
`define TM2_BIT_TX_BAUD    4
`define TM2_BIT_EXT_EN     3
`define TM2_BIT_RUN        2
`define TM2_BIT_SRC        1
`define TM2_BIT_CAP_RL     0

// reset values and counter constants
`define TM2_CTRL_RESET     8'h00
`define TM2_WORD_RESET     16'h0000
`define TM2_BYTE_ZERO      8'h00
`define TM2_WORD_ALL_ONES  16'hFFFF
`define TM2_WORD_ONE       16'h0001

// timebase divisors
`define TM2_DIV_SLOW       12
`define TM2_DIV_BAUD       2

`endif

// ### common/tm2_pkg.sv
`default_nettype none

package tm2_pkg;

  typedef enum logic [1:0] {
    TM2_OFF,
    TM2_CAPTURE,
    TM2_RELOAD,
    TM2_BAUD
  } tm2_mode_t;

endpackage

`default_nettype wire

// ### common/tm2_tick_if.sv
`timescale 1ns/10ps
`default_nettype none

interface tm2_tick_if;
  logic tick_slow;
  logic tick_baud;
  logic fall_count;
  logic fall_trig;

  modport gen (
    output tick_slow,
    output tick_baud,
    output fall_count,
    output fall_trig
  );
  modport use_side (
    input  tick_slow,
    input  tick_baud,
    input  fall_count,
    input  fall_trig
  );
endinterface

`default_nettype wire

// ### rtl/tm2_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none
`include "tm2_params.svh"

module tm2_tick_gen #(
  parameter int SLOW_DIV = `TM2_DIV_SLOW,
  parameter int BAUD_DIV = `TM2_DIV_BAUD
) (
  // clock and reset
  input  wire logic   mclk_in,
  input  wire logic   arst_n_in,
  // pins
  input  wire logic   ext_count_pin_in,
  input  wire logic   ext_trigger_pin_in,
  // ticks
  tm2_tick_if.gen     ticks
);

  localparam int SW = $clog2(SLOW_DIV);
  localparam int BW = $clog2(BAUD_DIV);

  if (SLOW_DIV < 2 || BAUD_DIV < 2) begin : g_bad_div
    $error("tm2_tick_gen: divisors must be at least 2");
  end

  logic [SW-1:0] slow_cnt;
  logic [SW-1:0] next_slow_cnt;
  logic [BW-1:0] baud_cnt;
  logic [BW-1:0] next_baud_cnt;
  logic          count_prev;
  logic          trig_prev;
  logic          tick_slow;
  logic          tick_baud;
  logic          fall_count;
  logic          fall_trig;
  logic          next_tick_slow;
  logic          next_tick_baud;
  logic          next_fall_count;
  logic          next_fall_trig;

  always_comb begin
    next_tick_slow  = (slow_cnt == SW'(SLOW_DIV - 1));
    next_slow_cnt   = next_tick_slow ? '0 : slow_cnt + SW'(1);
    next_tick_baud  = (baud_cnt == BW'(BAUD_DIV - 1));
    next_baud_cnt   = next_tick_baud ? '0 : baud_cnt + BW'(1);
    // high-to-low transitions on the two pins
    next_fall_count = count_prev & ~ext_count_pin_in;
    next_fall_trig  = trig_prev & ~ext_trigger_pin_in;
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      slow_cnt   <= '0;
      baud_cnt   <= '0;
      count_prev <= 1'b0;
      trig_prev  <= 1'b0;
      tick_slow  <= 1'b0;
      tick_baud  <= 1'b0;
      fall_count <= 1'b0;
      fall_trig  <= 1'b0;
    end else begin
      slow_cnt   <= next_slow_cnt;
      baud_cnt   <= next_baud_cnt;
      count_prev <= ext_count_pin_in;
      trig_prev  <= ext_trigger_pin_in;
      tick_slow  <= next_tick_slow;
      tick_baud  <= next_tick_baud;
      fall_count <= next_fall_count;
      fall_trig  <= next_fall_trig;
    end
  end

  assign ticks.tick_slow  = tick_slow;
  assign ticks.tick_baud  = tick_baud;
  assign ticks.fall_count = fall_count;
  assign ticks.fall_trig  = fall_trig;

endmodule

`default_nettype wire

// ### tb/tm2_uart_clk.sv
`timescale 1ns/10ps
`default_nettype none
module tm2_uart_clk (
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       arst_n_in,
  // overflow ticks
  input  wire logic       rx_tick_in,
  input  wire logic       tx_tick_in,
  // bit clocks seen
  output logic      [7:0] rx_baud_out,
  output logic      [7:0] tx_baud_out
);
  logic [3:0] rx_div;
  logic [3:0] tx_div;
  // variable-rate modes only; bit clock is tick rate over sixteen
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {rx_baud_out, rx_div} <= 12'h000;
      {tx_baud_out, tx_div} <= 12'h000;
    end else begin
      {rx_baud_out, rx_div} <= {rx_baud_out, rx_div} + {11'h000, rx_tick_in};
      {tx_baud_out, tx_div} <= {tx_baud_out, tx_div} + {11'h000, tx_tick_in};
    end
  end
endmodule
`default_nettype wire

// ### tb/tm2_timer_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module tm2_timer_monitor (
  // clock and reset
  input wire logic       mclk_in,
  input wire logic       arst_n_in,
  // register port
  input wire logic [7:0] sfr_addr_in,
  input wire logic       sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  // events
  input wire logic       timer_irq_req_out,
  input wire logic       rx_shift_tick_out,
  input wire logic       tx_shift_tick_out
);
  wire logic rd_ctrl = sfr_addr_in == 8'hC8 && !sfr_wr_in;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  a_ctrl_write: assert property (sfr_wr_in && sfr_addr_in == 8'hC8
    |=> sfr_rdata_out[5:0] == $past(sfr_wdata_in[5:0])) else $error("ctrl write lost");
  a_irq_flags: assert property (sfr_addr_in == 8'hC8
    |=> timer_irq_req_out == (sfr_rdata_out[7] | sfr_rdata_out[6])) else $error("irq off");
  a_irq_sticky: assert property (timer_irq_req_out && !sfr_wr_in
    |=> timer_irq_req_out) else $error("flag dropped");
  a_rx_tick_single: assert property (rx_shift_tick_out
    |=> !rx_shift_tick_out) else $error("rx tick long");
  a_tx_tick_single: assert property (tx_shift_tick_out
    |=> !tx_shift_tick_out) else $error("tx tick long");
  a_rx_tick_bit: assert property (!sfr_wr_in ##1 rd_ctrl ##1 rx_shift_tick_out
    |-> sfr_rdata_out[5]) else $error("rx tick unselected");
  a_tx_tick_bit: assert property (!sfr_wr_in ##1 rd_ctrl ##1 tx_shift_tick_out
    |-> sfr_rdata_out[4]) else $error("tx tick unselected");
  a_baud_no_flag: assert property (rd_ctrl && !sfr_rdata_out[7] ##1 rd_ctrl
    ##1 tx_shift_tick_out |-> !sfr_rdata_out[7]) else $error("baud set flag");
endmodule
bind tm2_timer tm2_timer_monitor u_mon (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
  .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in),
  .sfr_rdata_out(sfr_rdata_out), .timer_irq_req_out(timer_irq_req_out),
  .rx_shift_tick_out(rx_shift_tick_out), .tx_shift_tick_out(tx_shift_tick_out));
`default_nettype wire

// ### tb/tm2_timer_test.sv
`timescale 1ns/10ps
`default_nettype none
module tm2_timer_test;
  logic            mclk = 1'b0;
  logic            arst_n, wr, div, cpin, tpin;
  logic      [7:0] addr, wd;
  wire logic [7:0] rd, rxb, txb;
  wire logic       irq, rxt, txt;
  int              mismatches = 0, n_compared = 0, gap;
  logic            stalled = 1'b0;
  tm2_timer DUT (.mclk_in(mclk), .arst_n_in(arst_n), .sfr_addr_in(addr), .sfr_wr_in(wr),
    .sfr_wdata_in(wd), .sfr_rdata_out(rd), .clock_divide_select_in(div),
    .ext_count_pin_in(cpin), .ext_trigger_pin_in(tpin), .timer_irq_req_out(irq),
    .rx_shift_tick_out(rxt), .tx_shift_tick_out(txt));
  tm2_uart_clk u_uart (.mclk_in(mclk), .arst_n_in(arst_n), .rx_tick_in(rxt),
    .tx_tick_in(txt), .rx_baud_out(rxb), .tx_baud_out(txb));
  initial forever #2 mclk = ~mclk;
  task summarize;
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [7:0] got, lo, hi);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: %h not in %h..%h", $time, got, lo, hi);
    end
  endtask
  task w(input logic [7:0] a, d);
    @(posedge mclk);
    addr <= a;
    wd   <= d;
    wr   <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task r(input logic [7:0] a, lo, hi);
    @(posedge mclk);
    addr <= a;
    @(posedge mclk);
    @(negedge mclk);
    chk(rd, lo, hi);
  endtask
  // falling edge on trigger pin or count pin
  task fall(input logic trig);
    @(posedge mclk);
    if (trig) tpin <= 1'b0;
    else cpin <= 1'b0;
    repeat (3) @(posedge mclk);
    tpin <= 1'b1;
    cpin <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  // waits, a bounded number of cycles, for the next transmit tick
  task wait_tx;
    gap = 0;
    do begin
      @(negedge mclk);
      gap++;
    end while (txt !== 1'b1 && gap < 50);
    if (txt !== 1'b1) stalled = 1'b1;
  endtask
  initial begin
    for (int t = 0; t < 20000 && !stalled; t++) @(posedge mclk);
    mismatches++;
    summarize;
  end
  initial begin
    arst_n = 1'b0;
    wr     = 1'b0;
    div    = 1'b0;
    cpin   = 1'b1;
    tpin   = 1'b1;
    addr   = 8'h00;
    wd     = 8'h00;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    r(8'hC8, 8'h00, 8'h00);
    r(8'hCB, 8'h00, 8'h00);
    w(8'hC9, 8'h34);
    w(8'hCA, 8'h12);
    w(8'hCB, 8'hFE);
    w(8'hCC, 8'hFF);
    w(8'hC8, 8'h06);
    fall(1'b0);
    fall(1'b0);
    r(8'hC8, 8'h86, 8'h86);
    chk({7'h00, irq}, 8'h01, 8'h01);
    r(8'hCC, 8'h12, 8'h12);
    fall(1'b0);
    r(8'hCB, 8'h35, 8'h35);
    w(8'hC8, 8'h0E);
    fall(1'b1);
    r(8'hC8, 8'h4E, 8'h4E);
    r(8'hCB, 8'h34, 8'h34);
    w(8'hC8, 8'h07);
    fall(1'b1);
    r(8'hC8, 8'h07, 8'h07);
    w(8'hCB, 8'h77);
    w(8'hCC, 8'h66);
    w(8'hC8, 8'h0F);
    fall(1'b1);
    r(8'hCA, 8'h66, 8'h66);
    r(8'hC9, 8'h77, 8'h77);
    w(8'hCB, 8'hFF);
    w(8'hCC, 8'hFF);
    fall(1'b0);
    r(8'hCB, 8'h00, 8'h00);
    r(8'hC8, 8'hCF, 8'hCF);
    w(8'hC8, 8'h00);
    r(8'hC8, 8'h00, 8'h00);
    chk({7'h00, irq}, 8'h00, 8'h00);
    @(posedge mclk);
    div <= 1'b1;
    w(8'hC8, 8'h04);
    repeat (98) @(posedge mclk);
    w(8'hC8, 8'h00);
    r(8'hCB, 8'h64, 8'h64);
    @(posedge mclk);
    div <= 1'b0;
    w(8'hCB, 8'h00);
    w(8'hC8, 8'h04);
    repeat (118) @(posedge mclk);
    w(8'hC8, 8'h00);
    r(8'hCB, 8'h0A, 8'h0A);
    w(8'hC9, 8'hFE);
    w(8'hCA, 8'hFF);
    w(8'hCB, 8'hFE);
    w(8'hCC, 8'hFF);
    w(8'hC8, 8'h35);
    wait_tx;
    wait_tx;
    chk(8'(gap), 8'h04, 8'h04);
    repeat (200) @(posedge mclk);
    chk(rxb, 8'h03, 8'h03);
    chk(txb, 8'h03, 8'h03);
    r(8'hC8, 8'h35, 8'h35);
    w(8'hC8, 8'h3D);
    fall(1'b1);
    r(8'hC8, 8'h7D, 8'h7D);
    w(8'hC8, 8'h27);
    w(8'hCB, 8'hFE);
    w(8'hCC, 8'hFF);
    fall(1'b0);
    fall(1'b0);
    r(8'hCB, 8'hFF, 8'hFF);
    fall(1'b0);
    fall(1'b0);
    r(8'hCB, 8'hFE, 8'hFE);
    r(8'hC8, 8'h27, 8'h27);
    summarize;
  end
endmodule
`default_nettype wire
